// [iop_pkg.sv]
/*
 * Package for the input/output port pair: register offsets, field layout,
 * reset values and timing constants.
 * Assumes a 250 MHz system clock and a 32.768 kHz time-base tick input.
 */
package iop_pkg;

    // ------------------------------------------------------------
    // Register map (APB byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] input_port_level_off       = 8'h00;
    localparam logic [7:0] output_port_value_off      = 8'h04;
    localparam logic [7:0] port_pair_mode_control_off = 8'h08;
    localparam logic [7:0] irq_status_off             = 8'h0c;
    localparam logic [7:0] irq_mask_off               = 8'h10;

    // ------------------------------------------------------------
    // Mode control fields
    // ------------------------------------------------------------
    localparam int input_termination_select_bit = 0;
    localparam int output_drive_select_bit      = 1;
    localparam int pull_direction_select_bit    = 2;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [3:0] output_port_value_rst = 4'h0;
    localparam logic [3:0] mode_control_rst      = 4'h0;
    localparam logic [0:0] irq_mask_rst          = 1'h0;

    // ------------------------------------------------------------
    // Time base
    // ------------------------------------------------------------
    // 32768 Hz tick divided by 512 gives 64 Hz
    localparam int tbc_div_bits     = 9;
    localparam int ext1_vector_addr = 'h032;
    localparam logic [9:0] ext1_vector = 10'h032;

endpackage

// [iop_tbc.sv]
/*
 * Time-base divider: counts the 32.768 kHz tick down to 64 Hz and gives
 * a one-cycle pulse each time the counter's top bit falls.
 * Assumes xt_tick is a one-cycle enable synchronous to clk.
 */
module iop_tbc #(
    parameter int div_bits = iop_pkg::tbc_div_bits
) (
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst_n,
    // Time base
    input  wire logic xt_tick,
    output logic      hz64_fall
);

    typedef struct packed {
        logic [div_bits-1:0] count;
        logic                fall;
    } iop_tbc_state_type;

    iop_tbc_state_type state;
    iop_tbc_state_type next_state;

    always_comb begin
        next_state      = state;
        next_state.fall = 1'b0;
        if (xt_tick) begin
            next_state.count = div_bits'(state.count + 1'b1);
            // Top bit falls when counter wraps
            if (&state.count) begin
                next_state.fall = 1'b1; // RULE18
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign hz64_fall = state.fall;

endmodule

// [iop_port_pair.sv]
/*
 * Input/output port pair with shared mode control and External 1
 * interrupt. APB slave for registers.
 * Assumes pins synchronous to clk, xt_tick a 32.768 kHz enable pulse.
 */
// The register addresses and the APB interface to the registers were left to the implementer.
// Function
// RULE1: Read-only four-bit input level register
// RULE2: Output register drives pins, resets zero
// RULE3: Pins change at write completion
// RULE4: Port read captured at access edge
// RULE5: Mode control is write-only, reads zero
// RULE6: Bit 2 selects pull-up or pull-down
// RULE7: Same pull direction for ports two, three
// RULE8: Bit 1 selects push-pull or open drain
// RULE9: Bit 0 selects resistor or high-impedance
// RULE10: Mode bits clear on reset
// RULE11: Sample inputs on 64 Hz falling edge
// RULE12: Flag set within one sampling period
// RULE13: Flag from OR-based level change
// RULE14: Pull-down events: all low, any high
// RULE15: Pull-up events: any low, all high
// RULE16: Vector address 032H on acceptance
// RULE17: Pins 0 and 1 feed capture triggers
// RULE18: Sampling clock from crystal time base
// RULE19: Compare current and previous samples
module iop_port_pair (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst_n,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Time base
    input  wire logic        xt_tick,
    // Input port
    input  wire logic [3:0]  in_pins,
    output logic             in_pull_enable,
    output logic             in_pull_down,
    output logic [1:0]       capture_trigger,
    // Output port
    output logic [3:0]       out_pins,
    output logic [3:0]       out_pins_oe_n,
    // Shared with ports two and three
    output logic             port23_pull_down,
    // Interrupt
    output logic             ext1_interrupt_signal,
    output logic             irq,
    output logic [9:0]       ext1_vector_addr
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
        logic [3:0]  output_port_value;
        logic [3:0]  mode;
        logic        sample_valid;
        logic [3:0]  prev_sample;
        logic        ext1_request_flag;
        logic        irq_mask;
        logic        ext1_pulse;
        logic        irq;
        logic [3:0]  out_pins;
        logic [3:0]  oe_n;
        logic        pull_en;
        logic        pull_dn;
        logic [1:0]  cap_trig;
    } iop_state_type;

    iop_state_type state;
    iop_state_type next_state;
    logic          hz64_fall;
    logic          setup;
    logic          wr_done;
    logic          rd_done;
    logic          mapped;
    logic          event_hit;
    logic          all_hi_prev;
    logic          all_lo_prev;
    logic          all_hi_now;
    logic          all_lo_now;

    iop_tbc #(
        .div_bits (iop_pkg::tbc_div_bits)
    ) u_tbc (
        .clk       (clk),
        .rst_n     (rst_n),
        .xt_tick   (xt_tick),
        .hz64_fall (hz64_fall)
    );

    // ------------------------------------------------------------
    // Event detection
    // ------------------------------------------------------------
    // Only all-high/all-low states arm an event, as the OR circuit does
    always_comb begin
        all_hi_prev = &state.prev_sample;
        all_lo_prev = ~|state.prev_sample;
        all_hi_now  = &in_pins;
        all_lo_now  = ~|in_pins;
        event_hit   = 1'b0;
        if (hz64_fall && state.sample_valid) begin // RULE11 RULE19
            if (state.mode[iop_pkg::pull_direction_select_bit]) begin
                event_hit = (all_hi_prev && all_lo_now) // RULE14
                         || (all_lo_prev && !all_lo_now);
            end else begin
                event_hit = (all_hi_prev && !all_hi_now) // RULE15
                         || (all_lo_prev && all_hi_now);
            end
        end
    end

    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    always_comb begin
        setup   = psel && !penable;
        wr_done = psel && penable && pwrite && state.pready;
        rd_done = psel && penable && !pwrite && state.pready;
        case (paddr)
            iop_pkg::input_port_level_off,
            iop_pkg::output_port_value_off,
            iop_pkg::port_pair_mode_control_off,
            iop_pkg::irq_status_off,
            iop_pkg::irq_mask_off: mapped = 1'b1;
            default:               mapped = 1'b0;
        endcase
    end

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        next_state            = state;
        next_state.pready     = 1'b0;
        next_state.pslverr    = 1'b0;
        next_state.ext1_pulse = 1'b0;
        // No wait state: data is prepared in setup, answered next cycle
        if (setup) begin
            next_state.pready  = 1'b1;
            next_state.pslverr = !mapped;
            next_state.prdata  = 32'h0000_0000;
            if (!pwrite) begin
                case (paddr)
                    iop_pkg::input_port_level_off:
                        next_state.prdata = {28'h0, in_pins}; // RULE1 RULE4
                    iop_pkg::output_port_value_off:
                        next_state.prdata = {28'h0, state.output_port_value};
                    iop_pkg::irq_status_off:
                        next_state.prdata = {31'h0, state.ext1_request_flag};
                    iop_pkg::irq_mask_off:
                        next_state.prdata = {31'h0, state.irq_mask};
                    // Mode control is write-only, reads as zero
                    default:
                        next_state.prdata = 32'h0000_0000; // RULE5
                endcase
            end
        end
        if (wr_done && mapped) begin
            case (paddr)
                iop_pkg::output_port_value_off:
                    next_state.output_port_value = pwdata[3:0]; // RULE2
                iop_pkg::port_pair_mode_control_off:
                    next_state.mode = pwdata[3:0]; // RULE5
                iop_pkg::irq_mask_off:
                    next_state.irq_mask = pwdata[0];
                iop_pkg::irq_status_off:
                    if (pwdata[0]) begin
                        next_state.ext1_request_flag = 1'b0;
                    end
                default: ;
            endcase
        end
        if (rd_done) begin
            next_state.prdata = 32'h0000_0000;
        end
        // Sample history
        if (hz64_fall) begin
            next_state.prev_sample  = in_pins; // RULE11
            next_state.sample_valid = 1'b1;
        end
        // Set wins over a simultaneous write-one clear
        if (event_hit) begin
            next_state.ext1_request_flag = 1'b1; // RULE12 RULE13
            next_state.ext1_pulse        = 1'b1;
        end
        next_state.irq = next_state.ext1_request_flag && next_state.irq_mask;
        // Pins change together with the register, at the write edge
        next_state.out_pins = next_state.output_port_value; // RULE3
        for (int i = 0; i < 4; i++) begin
            // Open drain only drives low; enable is active low
            next_state.oe_n[i] = next_state.mode[iop_pkg::output_drive_select_bit]
                               && next_state.output_port_value[i]; // RULE8
        end
        next_state.pull_en  = !next_state.mode[iop_pkg::input_termination_select_bit]; // RULE9
        next_state.pull_dn  = next_state.mode[iop_pkg::pull_direction_select_bit]; // RULE6 RULE7
        next_state.cap_trig = in_pins[1:0]; // RULE17
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state                   <= '0;
            state.output_port_value <= iop_pkg::output_port_value_rst; // RULE2
            state.mode              <= iop_pkg::mode_control_rst; // RULE10
            state.irq_mask          <= iop_pkg::irq_mask_rst;
            state.pull_en           <= 1'b1;
        end else begin
            state <= next_state;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign prdata                = state.prdata;
    assign pready                = state.pready;
    assign pslverr               = state.pslverr;
    assign out_pins              = state.out_pins;
    assign out_pins_oe_n         = state.oe_n;
    assign in_pull_enable        = state.pull_en;
    assign in_pull_down          = state.pull_dn;
    assign port23_pull_down      = state.pull_dn;
    assign capture_trigger       = state.cap_trig;
    assign ext1_interrupt_signal = state.ext1_pulse;
    assign irq                   = state.irq;
    assign ext1_vector_addr      = iop_pkg::ext1_vector; // RULE16

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    // Steps of a register transfer; a write lands at the access edge
    sequence setup_s;
        psel && !penable;
    endsequence

    sequence access_wr_s;
        psel && penable && pwrite && pready;
    endsequence

    sequence wr_out_s;
        access_wr_s ##0 (paddr == iop_pkg::output_port_value_off);
    endsequence

    sequence wr_mode_s;
        access_wr_s ##0 (paddr == iop_pkg::port_pair_mode_control_off);
    endsequence

    sequence wr_clear_s;
        access_wr_s ##0 (paddr == iop_pkg::irq_status_off && pwdata[0]);
    endsequence

    sequence rd_in_s;
        setup_s ##0 (!pwrite && paddr == iop_pkg::input_port_level_off);
    endsequence

    sequence rd_mode_s;
        setup_s ##0 (!pwrite && paddr == iop_pkg::port_pair_mode_control_off);
    endsequence

    // Bus answer
    answer_next_a: assert property (@(posedge clk) disable iff (!rst_n)
        setup_s |=> pready)
        else $error("no answer after setup");
    answer_once_a: assert property (@(posedge clk) disable iff (!rst_n)
        pready |=> !pready)
        else $error("ready held longer than one cycle");
    unmapped_err_a: assert property (@(posedge clk) disable iff (!rst_n)
        setup_s ##0 !mapped |=> pslverr && pready)
        else $error("unmapped address not refused");
    in_read_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE1 RULE4
        rd_in_s |=> prdata[3:0] == $past(in_pins))
        else $error("input level read wrong");
    mode_read_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE5
        rd_mode_s |=> prdata == 32'h0)
        else $error("mode control read not zero");

    // Output port
    out_reg_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE2
        wr_out_s |=> state.output_port_value == $past(pwdata[3:0]))
        else $error("output register not written");
    out_follow_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE3
        wr_out_s |=> out_pins == $past(pwdata[3:0]))
        else $error("output pins did not follow write");
    out_quiet_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE3
        $changed(out_pins)
        |-> $past(wr_done) && $past(paddr) == iop_pkg::output_port_value_off)
        else $error("output pins changed without a write");
    od_drive_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE8
        out_pins_oe_n == ({4{state.mode[1]}} & state.output_port_value))
        else $error("output drive enable wrong");

    // Mode control and capture trigger
    mode_apply_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE6 RULE9
        wr_mode_s |=> in_pull_down == $past(pwdata[2]) && in_pull_enable == !$past(pwdata[0]))
        else $error("input termination not applied");
    pull_share_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE7
        wr_mode_s |=> port23_pull_down == $past(pwdata[2]))
        else $error("shared pull direction not applied");
    capture_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE17
        $past(rst_n) |-> capture_trigger == $past(in_pins[1:0]))
        else $error("capture trigger does not follow pins");

    // External 1 event
    sample_edge_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE11
        event_hit |-> hz64_fall)
        else $error("event outside sampling edge");
    first_sample_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE19
        !state.sample_valid |-> !event_hit)
        else $error("event without a previous sample");
    pd_event_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE14
        hz64_fall && state.sample_valid && state.mode[2] && all_lo_prev && !all_lo_now
        |-> event_hit)
        else $error("pull-down rising event missed");
    pd_fall_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE14
        hz64_fall && state.sample_valid && state.mode[2] && all_hi_prev && all_lo_now
        |-> event_hit)
        else $error("pull-down falling event missed");
    pu_event_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE15
        hz64_fall && state.sample_valid && !state.mode[2] && all_hi_prev && !all_hi_now
        |-> event_hit)
        else $error("pull-up falling event missed");
    pu_rise_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE15
        hz64_fall && state.sample_valid && !state.mode[2] && all_lo_prev && all_hi_now
        |-> event_hit)
        else $error("pull-up rising event missed");
    no_partial_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE13
        !all_hi_prev && !all_lo_prev
        |-> !event_hit)
        else $error("event from a mixed previous sample");
    flag_set_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE12
        event_hit |=> state.ext1_request_flag && ext1_interrupt_signal)
        else $error("event did not set flag");
    flag_src_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE13
        $rose(state.ext1_request_flag) |-> $past(event_hit))
        else $error("flag set without event");
    pulse_once_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE19
        ext1_interrupt_signal |=> !ext1_interrupt_signal)
        else $error("event pulse longer than one cycle");
    flag_clear_a: assert property (@(posedge clk) disable iff (!rst_n)
        wr_clear_s ##0 !event_hit |=> !state.ext1_request_flag)
        else $error("write one did not clear flag");

endmodule

// [iop_pins_model.sv]
/*
 * Pin-side model: switches on the input port, a pulled-up load on the
 * output port.
 * Assumes the bench sets the switches off the sampling edge.
 */
module iop_pins_model (
    // Clock
    input  wire logic       clk,
    // Switches, set by the bench
    input  wire logic [3:0] sw_level,
    input  wire logic [3:0] sw_closed,
    // Device side
    input  wire logic       in_pull_enable,
    input  wire logic       in_pull_down,
    input  wire logic [3:0] out_pins,
    input  wire logic [3:0] out_pins_oe_n,
    output logic      [3:0] in_pins,
    output logic      [3:0] load_level
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] last;

    always_ff @(posedge clk) last <= in_pins;

    always_comb begin
        for (int i = 0; i < 4; i++) begin
            if (sw_closed[i])
                in_pins[i] = sw_level[i];
            else if (in_pull_enable)
                in_pins[i] = ~in_pull_down;
            else
                in_pins[i] = ~last[i]; // Floating pin wanders
        end
    end

    // Released open drain reads high through the load
    assign load_level = out_pins | out_pins_oe_n;
endmodule

// [tb.sv]
/*
 * Self-checking bench for the port pair: APB master, pin model, event model.
 * Assumes xt_tick every second cycle, so one sampling period is 1024 cycles.
 */
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk = 1'b0, rst_n = 1'b0, xt_tick = 1'b0;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0, err;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic        pready, pslverr, pull_en, pull_dn, p23_dn, ext1, irq;
    logic [3:0]  sw_level = 4'h0, sw_closed = 4'hf, in_pins, out_pins, oe_n, load;
    logic [1:0]  cap;
    logic [9:0]  vec;
    int          fails = 0, n_compared = 0, n_ev = 0, base, prev, cur, pull_direction_select, mode, ov, lv;

    always #2 clk = ~clk;
    always @(posedge clk) xt_tick <= ~xt_tick;
    always @(posedge clk) if (ext1 === 1'b1) n_ev <= n_ev + 1;

    iop_port_pair i_iop_port_pair (.clk(clk), .rst_n(rst_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .xt_tick(xt_tick),
        .in_pins(in_pins), .in_pull_enable(pull_en), .in_pull_down(pull_dn),
        .capture_trigger(cap), .out_pins(out_pins), .out_pins_oe_n(oe_n),
        .port23_pull_down(p23_dn), .ext1_interrupt_signal(ext1), .irq(irq),
        .ext1_vector_addr(vec));

    iop_pins_model i_iop_pins_model (.clk(clk), .sw_level(sw_level),
        .sw_closed(sw_closed), .in_pull_enable(pull_en), .in_pull_down(pull_dn),
        .out_pins(out_pins), .out_pins_oe_n(oe_n), .in_pins(in_pins),
        .load_level(load));

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic give_verdict();
        $display("compared %0d, failed %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic apb(input bit wr, input logic [7:0] a, input logic [31:0] d);
        int k;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        for (k = 0; k < 20; k++) begin
            @(posedge clk);
            if (pready === 1'b1) break;
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (k == 20) begin
            fails++;
            give_verdict();
        end
    endtask

    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk("read", e, rd);
    endtask

    // Level-change model from the previous and current sample
    function automatic int ev(int p, int c, int pd);
        if (p == 15) return pd ? int'(c == 0) : int'(c != 15);
        if (p == 0) return pd ? int'(c != 0) : int'(c == 15);
        return 0;
    endfunction

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        void'($urandom(5));
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        chk("oe_n", 32'h0, oe_n);
        chk("pull_en", 32'h1, pull_en);
        chk("pull_dn", 32'h0, pull_dn);
        chk("vector", 32'h32, vec);
        rdc(8'h04, 32'h0);
        rdc(8'h08, 32'h0);
        apb(1'b0, 8'h14, 32'h0);
        chk("slverr", 32'h1, err);
        for (mode = 0; mode < 8; mode++) begin
            ov = $urandom % 16;
            apb(1'b1, 8'h04, ov);
            apb(1'b1, 8'h08, mode);
            repeat (2) @(posedge clk);
            chk("out_pins", ov, out_pins);
            chk("oe_n", mode[1] ? ov : 0, oe_n);
            chk("load", ov, load);
            chk("pull_en", !mode[0], pull_en);
            chk("pull_dn", mode[2], pull_dn);
            chk("p23_dn", mode[2], p23_dn);
            rdc(8'h04, ov);
            rdc(8'h08, 32'h0);
            if (!mode[0]) begin
                sw_closed <= 4'h0;
                rdc(8'h00, mode[2] ? 0 : 15);
            end
            lv = $urandom % 16;
            sw_closed <= 4'hf;
            sw_level <= lv;
            rdc(8'h00, lv);
            chk("capture", lv % 4, cap);
        end
        // Settle to all low so the history is known
        sw_level <= 4'h0;
        repeat (1100) @(posedge clk);
        apb(1'b1, 8'h0c, 32'h1);
        apb(1'b1, 8'h10, 32'h1);
        prev = 0;
        for (pull_direction_select = 0; pull_direction_select < 2; pull_direction_select++) begin
            apb(1'b1, 8'h08, pull_direction_select * 4);
            for (int s = 0; s < 12; s++) begin
                cur = ($urandom % 3 == 0) ? $urandom % 16 : (($urandom % 2) ? 15 : 0);
                base = n_ev;
                sw_level <= cur;
                // One sampling period plus the flag and irq latency
                repeat (1100) @(posedge clk);
                chk("events", ev(prev, cur, pull_direction_select), n_ev - base);
                chk("irq", ev(prev, cur, pull_direction_select), irq);
                rdc(8'h0c, ev(prev, cur, pull_direction_select));
                apb(1'b1, 8'h0c, 32'h1);
                repeat (2) @(posedge clk);
                chk("irq_clear", 32'h0, irq);
                prev = cur;
            end
        end
        // Masked event: status sets, irq stays low
        sw_level <= 4'h0;
        repeat (1100) @(posedge clk);
        apb(1'b1, 8'h0c, 32'h1);
        apb(1'b1, 8'h10, 32'h0);
        sw_level <= 4'hf;
        repeat (1100) @(posedge clk);
        chk("irq_masked", 32'h0, irq);
        rdc(8'h0c, 32'h1);
        // Reset in mid-run must undo what software wrote
        apb(1'b1, 8'h04, 32'ha);
        apb(1'b1, 8'h08, 32'h7);
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        chk("rst_out_pins", 32'h0, out_pins);
        chk("rst_oe_n", 32'h0, oe_n);
        chk("rst_pull_en", 32'h1, pull_en);
        chk("rst_pull_dn", 32'h0, pull_dn);
        rdc(8'h04, 32'h0);
        rdc(8'h0c, 32'h0);
        give_verdict();
    end
endmodule
